// ---- stdc_cfg.svh ----
// Purpose: constants of the system tick down counter
// Assumes: byte offsets within the counter's own address window
// Notes:   included by its bare name; definitions only
//
// Functional notes
// - tick counter is 24 bits, counts down while enabled, wraps at zero
// - once enabled, counting starts from the value the counter holds now
// - tick after reaching zero loads reload value, then keeps counting down
// - reached-zero flag sets when the count goes from one to zero
// - reading the control/status register clears the reached-zero flag
// - any write to current value clears counter and flag; reload follows
// - clearing the counter by a write never pends the tick exception
// - reading current value returns the live count at that access
// - reload of zero stops the counter at zero after the next wrap
// - counter holds while the processor is halted for debug
// - counter steps on processor clock or on an external reference
// - read-only calibration reports the preload for a 10 ms period
// - control/status holds clock select, enable, interrupt enable, status
// - tick exception priority sits in bits 31:30 of handler priority three
// - with interrupt enable bit 1 set, count to zero pends the exception
// - clock select bit 2: 0 external, 1 processor; fixed 1 without external
// - enable bit 0: 0 stops the counter, 1 lets it run
// - reload holds bits 23:0; upper bits read zero, writes ignored
`ifndef STDC_CFG_SVH
`define STDC_CFG_SVH

`define STDC_OFF_CTRL      12'h010
`define STDC_OFF_RELOAD    12'h014
`define STDC_OFF_CURRENT   12'h018
`define STDC_OFF_CALIB     12'h01C
`define STDC_OFF_PRIO3     12'h020

`define STDC_BIT_ENABLE    0
`define STDC_BIT_TICK_INTERRUPT_ENABLE   1
`define STDC_BIT_CLKSEL    2
`define STDC_BIT_FLAG      16
`define STDC_PRIO_HI       31
`define STDC_PRIO_LO       30

`define STDC_RST_ENABLE    1'b0
`define STDC_RST_TICK_INTERRUPT_ENABLE   1'b0
`define STDC_RST_CLKSEL    1'b1
`define STDC_RST_PRIO      2'h0

`define STDC_CALIB_PERIOD_US 10000
`define STDC_CLK_FREQ_MHZ    10

`endif

// ---- stdc_pkg.sv ----
// Purpose: types shared by the system tick down counter
// Assumes: nothing beyond the config header
// Notes:   carries the control fields and the captured bus address phase
package stdc_pkg;

  typedef struct packed {
    logic clk_sel;
    logic tick_int_en;
    logic enable;
  } stdc_ctrl_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } stdc_aphase_s;

endpackage

// ---- stdc_timer.sv ----
// Purpose: system tick down counter with an AHB-Lite register slave
// Assumes: halt input comes from logic on hclk; ext_ref_clk is a pin
// Notes:   zero wait states; reads are taken at the address phase
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "stdc_cfg.svh"

module stdc_timer #(
  parameter int CNT_W       = 24,
  parameter bit HAS_EXT_CLK = 1'b1
) (
  // bus clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // reference clock pin and debug halt
  input  wire logic        ext_ref_clk,
  input  wire logic        debug_halted,
  // exception side
  output logic             tick_pend,
  output logic      [1:0]  tick_exception_priority
);

  localparam int CALIB_CYC =
    `STDC_CALIB_PERIOD_US * `STDC_CLK_FREQ_MHZ;
  localparam logic [23:0] CALIB_VAL = 24'(CALIB_CYC - 1);

  generate
    if (CNT_W < 17 || CNT_W > 24) begin : g_bad_width
      $error("CNT_W must lie between 17 and 24");
    end
  endgenerate

  // register state
  stdc_pkg::stdc_ctrl_s   ctrl_q;
  stdc_pkg::stdc_aphase_s aph_q;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       cnt_d;
  logic [CNT_W-1:0]       reload_q;
  logic                   flag_q;
  logic                   flag_d;
  logic                   pend_q;
  logic                   pend_d;
  logic [1:0]             prio_q;
  logic [31:0]            rdata_q;
  logic                   ready_q;
  logic                   resp_q;

  // reference clock synchroniser
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;

  // bus decode
  wire logic take     = hsel & htrans[1] & hready;
  wire logic rd_take  = take & ~hwrite;
  wire logic wr_data  = aph_q.valid & aph_q.write;
  wire logic wr_ctrl  = wr_data & (aph_q.addr == `STDC_OFF_CTRL);
  wire logic wr_rel   = wr_data & (aph_q.addr == `STDC_OFF_RELOAD);
  wire logic wr_cur   = wr_data & (aph_q.addr == `STDC_OFF_CURRENT);
  wire logic wr_prio  = wr_data & (aph_q.addr == `STDC_OFF_PRIO3);
  wire logic rd_ctrl  = rd_take & (haddr == `STDC_OFF_CTRL);

  // count step source
  wire logic ext_edge = ref_s2_q & ~ref_s3_q;
  wire logic src_tick = ctrl_q.clk_sel | ext_edge;
  wire logic step     = ctrl_q.enable & ~debug_halted
                        & src_tick;
  wire logic at_zero  = (cnt_q == '0);
  wire logic at_one   = (cnt_q == CNT_W'(1));
  wire logic hits_0   = step & at_one;

  // read mux, zero-extended fields
  wire logic [31:0] rd_ctrl_w = {15'h0000, flag_q, 13'h0000,
                                 ctrl_q.clk_sel, ctrl_q.tick_int_en,
                                 ctrl_q.enable};
  wire logic [31:0] rd_rel_w  = 32'(reload_q);
  wire logic [31:0] rd_cur_w  = 32'(cnt_q);
  wire logic [31:0] rd_cal_w  = {8'h00, CALIB_VAL};
  wire logic [31:0] rd_pri_w  = {prio_q, 30'h00000000};
  wire logic [31:0] rd_mux =
    (haddr == `STDC_OFF_CTRL)    ? rd_ctrl_w :
    (haddr == `STDC_OFF_RELOAD)  ? rd_rel_w  :
    (haddr == `STDC_OFF_CURRENT) ? rd_cur_w  :
    (haddr == `STDC_OFF_CALIB)   ? rd_cal_w  :
    (haddr == `STDC_OFF_PRIO3)   ? rd_pri_w  : 32'h00000000;

  // counter next value
  always_comb begin
    cnt_d = cnt_q;
    if (wr_cur) begin
      cnt_d = '0;
    end else if (step) begin
      if (at_zero) begin
        cnt_d = reload_q;
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  // flag: a set wins over a control read clear in the same cycle; a current value write clears
  always_comb begin
    flag_d = flag_q;
    if (rd_ctrl || wr_cur) begin
      flag_d = 1'b0;
    end
    if (hits_0 && !wr_cur) begin
      flag_d = 1'b1;
    end
  end

  // pend only on a real count to zero, never on a write clear
  always_comb begin
    pend_d = hits_0 & ~wr_cur & ctrl_q.tick_int_en;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      ref_s1_q <= ext_ref_clk;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= '0;
    end else if (hready) begin
      aph_q <= '{valid: take, write: hwrite, addr: haddr};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= '{clk_sel:     `STDC_RST_CLKSEL,
                  tick_int_en: `STDC_RST_TICK_INTERRUPT_ENABLE,
                  enable:      `STDC_RST_ENABLE};
    end else if (wr_ctrl) begin
      ctrl_q.enable      <= hwdata[`STDC_BIT_ENABLE];
      ctrl_q.tick_int_en <= hwdata[`STDC_BIT_TICK_INTERRUPT_ENABLE];
      ctrl_q.clk_sel     <= HAS_EXT_CLK ?
                            hwdata[`STDC_BIT_CLKSEL] : 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_q <= '0;
    end else if (wr_rel) begin
      reload_q <= hwdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prio_q <= `STDC_RST_PRIO;
    end else if (wr_prio) begin
      prio_q <= hwdata[`STDC_PRIO_HI:`STDC_PRIO_LO];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= '0;
      flag_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      flag_q <= flag_d;
      pend_q <= pend_d;
    end
  end

  // bus answer: always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end else begin
      rdata_q <= rd_take ? rd_mux : 32'h00000000;
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end
  end

  assign hrdata                  = rdata_q;
  assign hreadyout               = ready_q;
  assign hresp                   = resp_q;
  assign tick_pend               = pend_q;
  assign tick_exception_priority = prio_q;

endmodule

// ---- stdc_asserts.sv ----
// Purpose: port checks of the tick down counter
// Assumes: zero wait state slave, hready fed from hreadyout
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module stdc_asserts (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // counter side
  input wire logic        debug_halted,
  input wire logic        tick_pend,
  input wire logic [1:0]  tick_exception_priority
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire tk = hsel && htrans[1] && hready;
  wire rd = tk && !hwrite;
  property p_cal;
    rd && haddr == 12'h01C |=> hrdata == 32'h0001869F; endproperty
  a_cal: assert property (p_cal) else $error("bad calibration");
  property p_rld;
    rd && haddr == 12'h014 |=> hrdata[31:24] == 8'h00; endproperty
  a_rld: assert property (p_rld) else $error("reload upper bits");
  property p_ctl;
    rd && haddr == 12'h010 |=> (hrdata & 32'hFFFEFFF8) == 32'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("control spare bits");
  property p_pri;
    rd && haddr == 12'h020 |=>
    hrdata == {$past(tick_exception_priority), 30'h0}; endproperty
  a_pri: assert property (p_pri) else $error("priority readback");
  property p_idle;
    !rd |=> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside phase");
  property p_pls;
    tick_pend |=> !tick_pend; endproperty
  a_pls: assert property (p_pls) else $error("pend not one cycle");
  property p_hlt;
    tick_pend |-> !$past(debug_halted); endproperty
  a_hlt: assert property (p_hlt) else $error("step while halted");
  property p_wcv;
    tk && hwrite && haddr == 12'h018 |-> ##2 !tick_pend; endproperty
  a_wcv: assert property (p_wcv) else $error("pend on clear");
endmodule

// ---- stdc_tb.sv ----
// Purpose: self-checking bench of the tick down counter
// Assumes: zero wait state slave, hready fed from hreadyout
// Notes:   reload values from a fixed seed
`timescale 1ns/1ps
`include "stdc_cfg.svh"
module testbench;
  logic        hclk, hresetn, hsel, hwrite, ext_ref_clk, debug_halted;
  logic        hreadyout, hresp, tick_pend;
  logic [1:0]  htrans, tick_exception_priority;
  logic [11:0] haddr;
  logic [31:0] hwdata, hrdata, r, s;
  int          mismatches, num_checks, cyc, seed, p, n;
  logic [31:0] rv [6] = '{32'h4, 32'h0, 32'h0, 32'h0001869F, 32'h0, 32'h0};
  stdc_timer stdc_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_ref_clk(ext_ref_clk),
    .debug_halted(debug_halted), .tick_pend(tick_pend),
    .tick_exception_priority(tick_exception_priority));
  always #50 hclk = ~hclk;
  // reference pin toggles every 3 cycles; timeout at cycle 5000
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) ext_ref_clk <= ~ext_ref_clk;
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer; a write adds an idle edge so reads see it
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    if (w) @(posedge hclk);
  endtask
  task automatic wait_pend(input int lim);
    p = 0;
    repeat (lim) begin
      @(posedge hclk);
      if (tick_pend === 1'b1) p++;
    end
  endtask
  initial begin
    {hclk, hresetn, hsel, hwrite, ext_ref_clk, debug_halted} = 6'h0;
    {haddr, htrans, hwdata} = 46'h0;
    {mismatches, num_checks, cyc} = 96'h0;
    seed = 32'h4069;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, 12'h010 + 12'(i * 4), 32'h0);
      chk(r, rv[i]);
    end
    s = $random(seed);
    xfer(1'b1, `STDC_OFF_PRIO3, s);
    xfer(1'b0, `STDC_OFF_PRIO3, 32'h0);
    chk(r, s & 32'hC0000000);
    chk({30'h0, tick_exception_priority}, {30'h0, s[31:30]});
    $display("reset values and priority done");
    s = 32'hFF000200 | ($random(seed) & 32'h1FF);
    xfer(1'b1, `STDC_OFF_RELOAD, s);
    xfer(1'b0, `STDC_OFF_RELOAD, 32'h0);
    chk(r, s & 32'h00FFFFFF);
    xfer(1'b1, `STDC_OFF_CURRENT, $random(seed));
    xfer(1'b0, `STDC_OFF_CURRENT, 32'h0);
    chk(r, 32'h0);
    // enable, halt, disable, external reference: live read pairs
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, `STDC_OFF_CTRL, k == 3 ? 32'h1 : 32'h5 - 32'(k / 2));
      debug_halted <= (k == 1);
      xfer(1'b0, `STDC_OFF_CURRENT, 32'h0);
      s = r;
      if (k == 3) repeat (4) @(posedge hclk);
      xfer(1'b0, `STDC_OFF_CURRENT, 32'h0);
      n = (k == 0) ? 2 : int'(k == 3);
      chk(r, s - 32'(n));
      debug_halted <= 1'b0;
    end
    $display("live count done");
    xfer(1'b1, `STDC_OFF_CTRL, 32'h0);
    n = 4 + ($random(seed) & 3);
    xfer(1'b1, `STDC_OFF_RELOAD, 32'(n));
    xfer(1'b1, `STDC_OFF_CURRENT, 32'h0);
    xfer(1'b1, `STDC_OFF_CTRL, 32'h7);
    wait_pend(3 * (n + 1));
    chk(p, 3);
    xfer(1'b0, `STDC_OFF_CTRL, 32'h0);
    chk({31'h0, r[16]}, 32'h1);
    xfer(1'b0, `STDC_OFF_CTRL, 32'h0);
    chk({31'h0, r[16]}, 32'h0);
    xfer(1'b1, `STDC_OFF_CTRL, 32'h5);
    wait_pend(3 * (n + 1));
    chk(p, 0);
    $display("wrap and pend done");
    xfer(1'b1, `STDC_OFF_RELOAD, 32'h0);
    wait_pend(2 * (n + 1));
    repeat (2) begin
      xfer(1'b0, `STDC_OFF_CURRENT, 32'h0);
      chk(r, 32'h0);
    end
    $display("zero reload done");
    print_verdict;
  end
endmodule
bind stdc_timer stdc_asserts stdc_asserts_inst (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .debug_halted(debug_halted), .tick_pend(tick_pend),
  .tick_exception_priority(tick_exception_priority));
